// ---- asc_defs.svh ----
// Purpose: Constants for the converter control block.
// Assumes: Included by the package and by every design file.
// Notes: Times are in nanoseconds; counts derive from the clock period.
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_RES_W 10
`define ASC_BYTE_W 8
`define ASC_CH_W 3
`define ASC_CH_TEMP 3'h0
`define ASC_CH_BANDGAP 3'h7
`define ASC_OTR_RESET 8'h99
`define ASC_CLK_NS 10
`define ASC_CONV_NS 9000
`define ASC_CONV_CYC ((`ASC_CONV_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_CNT_W 10
`define ASC_BITCNT_W 4
`define ASC_FIFO_DEPTH 8
`define ASC_FIFO_AW 3
`define ASC_SYNC_W 7
`define ASC_SYNC_RESET 7'h1B
`endif

// ---- asc_pkg.sv ----
// Purpose: Shared types for the converter control block.
// Assumes: Constants come from asc_defs.svh.
// Notes: Holds types only.
`include "asc_defs.svh"
package asc_pkg;
  typedef struct packed {
    logic [`ASC_CH_W-1:0] channel;
    logic [`ASC_RES_W-1:0] code;
  } asc_result_t;
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_CONVERT,
    ASC_POWER_DOWN
  } asc_conv_state_t;
endpackage

// ---- asc_fifo.sv ----
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; the enable input freezes all state.
// Notes: Full and empty come straight from the occupancy count.
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = `ASC_FIFO_DEPTH,
  parameter int AW = `ASC_FIFO_AW
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = clk_en && in_valid && in_ready;
  assign pop = clk_en && out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // asc_fifo

// ---- asc_conv_ctrl.sv ----
// Purpose: Digital control of a serial-port converter with temperature sensor.
// Assumes: Serial clock, select and start pins are asynchronous to clk_sys.
// Notes: The analog core is outside; a result arrives on result_code.
`timescale 1ns/1ps
`include "asc_defs.svh"
// Summary of operation
// - A falling convert_start_n edge starts a 10-bit conversion.
// - Sampler holds from that edge until conversion ends, then tracks.
// - Convert_start_n low at conversion end enters power-down.
// - Temperature result above threshold drives over_temp_alert_n low.
// - Falling read/write select ends a read; rising select releases the alert.
// - Output bits launch on falling serial clock; input captured rising.
// - Separate output tri-states when select falls or chip select rises.
// - Shared pin carries both directions, direction set by select level.
// - The channel register written by the host picks the converted source.
// - Zero top five bits load channel, else byte loads threshold.
// - Channel 000 temperature, 001-100 inputs, 111 bandgap; resets 000.
// - Compare uses the top eight bits of the ten-bit temperature result.
// - Busy output is high for the whole of every conversion.
module asc_conv_ctrl
  import asc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic convert_start_n,
  input wire logic serial_clk,
  input wire logic read_select,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic shared_pin_mode,
  input wire logic shared_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic shared_data_out,
  output logic shared_data_oe,
  input wire logic [`ASC_RES_W-1:0] result_code,
  output logic track_hold,
  output logic [`ASC_CH_W-1:0] channel_select,
  output logic busy,
  output logic power_down,
  output logic over_temp_alert_n,
  output logic [`ASC_BYTE_W-1:0] over_temp_threshold
);
  // Two-flop synchronisers; the second stage and its delayed copy prev are read.
  logic [`ASC_SYNC_W-1:0] sync_a;
  logic [`ASC_SYNC_W-1:0] sync_1;
  logic [`ASC_SYNC_W-1:0] sync_b;
  logic [`ASC_SYNC_W-1:0] prev;
  logic mode_s;
  logic cs_n_s;
  logic sclk_s;
  logic rd_s;
  logic cst_n_s;
  logic din_s;
  logic sclk_rise;
  logic sclk_fall;
  logic rd_rise;
  logic rd_fall;
  logic cs_rise;
  logic cst_fall;
  asc_conv_state_t state;
  logic [`ASC_CNT_W-1:0] conv_cnt;
  logic conv_done;
  logic [`ASC_BYTE_W-1:0] rx_shift;
  logic [`ASC_BITCNT_W-1:0] rx_cnt;
  logic [`ASC_RES_W-1:0] tx_shift;
  logic tx_active;
  logic fifo_ready;
  logic res_valid;
  asc_result_t res_in;
  asc_result_t res_out;
  logic tx_load;
  logic tx_valid_w;

  assign sync_a[0] = chip_select_n;
  assign sync_a[1] = serial_clk;
  assign sync_a[2] = read_select;
  assign sync_a[3] = convert_start_n;
  assign sync_a[4] = serial_data_in;
  assign sync_a[5] = shared_data_in;
  assign sync_a[6] = shared_pin_mode;

  // Reset values match the idle pin levels so no false edge follows reset.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_1 <= `ASC_SYNC_RESET;
      sync_b <= `ASC_SYNC_RESET;
      prev <= `ASC_SYNC_RESET;
    end else if (clk_en) begin
      sync_1 <= sync_a;
      sync_b <= sync_1;
      prev <= sync_b;
    end
  end

  assign cs_n_s = sync_b[0];
  assign sclk_s = sync_b[1];
  assign rd_s = sync_b[2];
  assign cst_n_s = sync_b[3];
  assign mode_s = sync_b[6];
  assign din_s = mode_s ? sync_b[5] : sync_b[4];
  assign sclk_rise = sclk_s && !prev[1] && !cs_n_s;
  assign sclk_fall = !sclk_s && prev[1] && !cs_n_s;
  assign rd_rise = rd_s && !prev[2];
  assign rd_fall = !rd_s && prev[2];
  assign cs_rise = cs_n_s && !prev[0];
  assign cst_fall = !cst_n_s && prev[3];
  assign conv_done = (state == ASC_CONVERT) &&
    (conv_cnt == `ASC_CNT_W'(`ASC_CONV_CYC - 1));

  // Conversion sequencer; power-down is left by the next start edge.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= ASC_IDLE;
      conv_cnt <= '0;
    end else if (clk_en) begin
      unique case (state)
        ASC_IDLE, ASC_POWER_DOWN: begin
          conv_cnt <= '0;
          if (cst_fall) begin
            state <= ASC_CONVERT;
          end
        end
        ASC_CONVERT: begin
          conv_cnt <= conv_cnt + 1'b1;
          if (conv_done) begin
            state <= cst_n_s ? ASC_IDLE : ASC_POWER_DOWN;
          end
        end
      endcase
    end
  end

  assign busy = (state == ASC_CONVERT);
  assign track_hold = (state == ASC_CONVERT);
  assign power_down = (state == ASC_POWER_DOWN);

  // Control byte receive path, written while read select is low.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_shift <= '0;
      rx_cnt <= '0;
      channel_select <= `ASC_CH_TEMP;
      over_temp_threshold <= `ASC_OTR_RESET;
    end else if (clk_en) begin
      if (cs_n_s || rd_s) begin
        rx_cnt <= '0;
      end else if (sclk_rise) begin
        rx_shift <= {rx_shift[`ASC_BYTE_W-2:0], din_s};
        if (rx_cnt == `ASC_BITCNT_W'(`ASC_BYTE_W - 1)) begin
          rx_cnt <= '0;
          if (rx_shift[`ASC_BYTE_W-2:`ASC_CH_W-1] == '0) begin
            channel_select <= {rx_shift[`ASC_CH_W-2:0], din_s};
          end else begin
            over_temp_threshold <= {rx_shift[`ASC_BYTE_W-2:0], din_s};
          end
        end else begin
          rx_cnt <= rx_cnt + 1'b1;
        end
      end
    end
  end

  // The channel in use is the register's current value at conversion end.
  assign res_in.channel = channel_select;
  assign res_in.code = result_code;
  assign res_valid = conv_done;

  // Results queue so a slow host read loses no result unless 8 are already waiting.
  asc_fifo #(
    .WIDTH($bits(asc_result_t)),
    .DEPTH(`ASC_FIFO_DEPTH),
    .AW(`ASC_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .in_data(res_in),
    .in_valid(res_valid),
    .in_ready(fifo_ready),
    .out_data(res_out),
    .out_valid(tx_valid_w),
    .out_ready(tx_load)
  );

  assign tx_load = tx_valid_w && !tx_active && rd_s && !cs_n_s;

  // Read path: load at read start, shift on falling serial clock.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_shift <= '0;
      tx_active <= 1'b0;
    end else if (clk_en) begin
      if (rd_fall || cs_rise) begin
        tx_active <= 1'b0;
      end else if (tx_load) begin
        tx_shift <= res_out.code;
        tx_active <= 1'b1;
      end else if (tx_active && sclk_fall) begin
        tx_shift <= {tx_shift[`ASC_RES_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      over_temp_alert_n <= 1'b1;
    end else if (clk_en) begin
      if (conv_done && channel_select == `ASC_CH_TEMP &&
          result_code[`ASC_RES_W-1:`ASC_RES_W-`ASC_BYTE_W] >
          over_temp_threshold) begin
        over_temp_alert_n <= 1'b0;
      end else if (rd_rise && !cs_n_s) begin
        over_temp_alert_n <= 1'b1;
      end
    end
  end

  assign serial_data_out = tx_shift[`ASC_RES_W-1];
  assign serial_data_oe = tx_active && !mode_s;
  assign shared_data_out = tx_shift[`ASC_RES_W-1];
  assign shared_data_oe = tx_active && mode_s;

  a_alert_set: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && conv_done && channel_select == `ASC_CH_TEMP &&
    result_code[`ASC_RES_W-1:`ASC_RES_W-`ASC_BYTE_W] > over_temp_threshold
    |=> !over_temp_alert_n) else $error("alert not set");
  a_start_conv: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && cst_fall && state != ASC_CONVERT |=> busy)
    else $error("start missed");
  a_busy_len: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(busy) && clk_en |-> busy[*8]) else $error("busy short");
  a_power_down: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && conv_done && !cst_n_s |=> power_down)
    else $error("no power down");
  a_oe_drop: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && (rd_fall || cs_rise) |=> !serial_data_oe && !shared_data_oe)
    else $error("output not released");
  a_shared_excl: assert property (@(posedge clk_sys) disable iff (reset)
    !(serial_data_oe && shared_data_oe)) else $error("both drive");
  a_hold_busy: assert property (@(posedge clk_sys) disable iff (reset)
    track_hold == busy) else $error("hold mismatch");
  a_alert_clr: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && rd_rise && !cs_n_s && !conv_done |=> over_temp_alert_n)
    else $error("alert not cleared");

  // Start is two steps: an edge is seen, then hold and busy rise together.
  sequence s_start_seen;
    clk_en && cst_fall && state != ASC_CONVERT;
  endsequence
  sequence s_hold_taken;
    busy && track_hold && !power_down;
  endsequence
  a_start_hold: assert property (@(posedge clk_sys) disable iff (reset)
    s_start_seen |=> s_hold_taken) else $error("hold not taken");
endmodule // asc_conv_ctrl

// ---- asc_host_model.sv ----
// Purpose: Host model that drives the serial port of the converter block.
// Assumes: Serial clock idles high and stands still between frames.
// Notes: Released data shows the inverse of its last value.
`timescale 1ns/1ps
module asc_host_model (
  output logic serial_clk,
  output logic read_select,
  output logic chip_select_n,
  output logic host_data,
  input wire logic rx_line
);
  localparam realtime HALF = 62.5;
  initial begin
    serial_clk = 1'b1;
    read_select = 1'b0;
    chip_select_n = 1'b1;
    host_data = 1'b0;
  end
  task automatic write_byte(input logic [7:0] b);
    read_select <= 1'b0;
    chip_select_n <= 1'b0;
    #(2*HALF);
    for (int i = 7; i >= 0; i--) begin
      serial_clk <= 1'b0;
      host_data <= b[i];
      #HALF serial_clk <= 1'b1;
      #HALF;
    end
    #(2*HALF) chip_select_n <= 1'b1;
    // A stale level would let a sloppy capture pass by luck.
    host_data <= ~host_data;
    #(4*HALF);
  endtask
  task automatic read_word(output logic [9:0] w);
    read_select <= 1'b1;
    #HALF chip_select_n <= 1'b0;
    #(4*HALF);
    for (int i = 9; i >= 0; i--) begin
      w[i] = rx_line;
      serial_clk <= 1'b0;
      #HALF serial_clk <= 1'b1;
      #HALF;
    end
    read_select <= 1'b0;
    #(4*HALF);
  endtask
  task automatic end_read(input logic clr);
    if (clr) begin
      read_select <= 1'b1;
    end
    #(4*HALF) chip_select_n <= 1'b1;
    #(4*HALF);
  endtask
endmodule // asc_host_model

// ---- tb_adc_serial_port_conv_ctrl.sv ----
// Purpose: Self-checking bench for the converter control block.
// Assumes: The host model drives the serial port at an 8 MHz clock.
// Notes: Conversion length is the full 900 cycles.
`timescale 1ns/1ps
`include "asc_defs.svh"
`define CHK(got, exp) \
  begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_adc_serial_port_conv_ctrl;
  logic clk_sys, reset, convert_start_n, shared_pin_mode, clk_en;
  logic [`ASC_RES_W-1:0] result_code;
  logic serial_clk, read_select, chip_select_n, host_data;
  logic serial_data_out, serial_data_oe, shared_data_out, shared_data_oe;
  logic track_hold, busy, power_down, over_temp_alert_n;
  logic [`ASC_CH_W-1:0] channel_select;
  logic [`ASC_BYTE_W-1:0] over_temp_threshold;
  logic shared_line, rx_line;
  int num_errors, num_checks, cycles;
  assign shared_line = shared_data_oe ? shared_data_out : host_data;
  assign rx_line = shared_pin_mode ? shared_line : serial_data_out;
  asc_conv_ctrl asc_conv_ctrl_i (.clk_sys(clk_sys), .reset(reset),
    .clk_en(clk_en), .convert_start_n(convert_start_n),
    .serial_clk(serial_clk), .read_select(read_select),
    .chip_select_n(chip_select_n), .serial_data_in(host_data),
    .shared_pin_mode(shared_pin_mode), .shared_data_in(shared_line),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .shared_data_out(shared_data_out), .shared_data_oe(shared_data_oe),
    .result_code(result_code), .track_hold(track_hold),
    .channel_select(channel_select), .busy(busy), .power_down(power_down),
    .over_temp_alert_n(over_temp_alert_n),
    .over_temp_threshold(over_temp_threshold));
  asc_host_model asc_host_model_i (.serial_clk(serial_clk),
    .read_select(read_select), .chip_select_n(chip_select_n),
    .host_data(host_data), .rx_line(rx_line));
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The serial runs take about 5000 cycles; this ceiling leaves margin.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_reset();
    `CHK(busy, 1'b0)
    `CHK(channel_select, `ASC_CH_TEMP)
    `CHK(over_temp_threshold, `ASC_OTR_RESET)
    `CHK(over_temp_alert_n, 1'b1)
    `CHK(serial_data_oe, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_write();
    logic [2:0] codes [6] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    foreach (codes[i]) begin
      asc_host_model_i.write_byte({5'h00, codes[i]});
      settle(4);
      `CHK(channel_select, codes[i])
    end
    asc_host_model_i.write_byte(8'h20);
    settle(4);
    `CHK(over_temp_threshold, 8'h20)
    `CHK(channel_select, 3'h0)
    $display("test write done");
  endtask
  task automatic convert(input logic [9:0] code, input logic stay_low,
                         input logic exp_alert_n);
    int n;
    n = 0;
    @(posedge clk_sys);
    result_code <= code;
    convert_start_n <= 1'b0;
    settle(1);
    while (busy !== 1'b1 && n < 10) begin
      settle(1);
      n++;
    end
    `CHK(busy, 1'b1)
    `CHK(track_hold, 1'b1)
    @(posedge clk_sys);
    convert_start_n <= ~stay_low;
    #1;
    n = 1;
    while (busy === 1'b1 && n < 1000) begin
      settle(1);
      n++;
    end
    `CHK(n, 900)
    settle(3);
    `CHK(track_hold, 1'b0)
    `CHK(power_down, stay_low)
    `CHK(over_temp_alert_n, exp_alert_n)
    @(posedge clk_sys);
    convert_start_n <= 1'b1;
    $display("test convert done");
  endtask
  task automatic t_read(input logic mode, input logic [9:0] exp,
                        input logic clr);
    logic [9:0] w;
    @(posedge clk_sys);
    shared_pin_mode <= mode;
    settle(4);
    asc_host_model_i.read_word(w);
    `CHK(w, exp)
    `CHK(mode ? shared_data_oe : serial_data_oe, 1'b0)
    asc_host_model_i.end_read(clr);
    `CHK(over_temp_alert_n, 1'b1)
    $display("test read done");
  endtask
  // A start edge that arrives while frozen must never be seen later.
  task automatic t_freeze();
    @(posedge clk_sys);
    clk_en <= 1'b0;
    convert_start_n <= 1'b0;
    settle(5);
    `CHK(busy, 1'b0)
    @(posedge clk_sys);
    convert_start_n <= 1'b1;
    settle(5);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    settle(5);
    `CHK(busy, 1'b0)
    `CHK(power_down, 1'b0)
    $display("test freeze done");
  endtask
  task automatic t_shared_write();
    asc_host_model_i.write_byte(8'h04);
    settle(4);
    `CHK(channel_select, 3'h4)
    $display("test shared write done");
  endtask
  initial begin
    reset = 1'b1;
    convert_start_n = 1'b1;
    shared_pin_mode = 1'b0;
    clk_en = 1'b1;
    result_code = 10'h000;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    settle(4);
    t_reset();
    t_freeze();
    t_write();
    convert(10'h2A5, 1'b1, 1'b0);
    t_read(1'b0, 10'h2A5, 1'b1);
    asc_host_model_i.write_byte(8'h01);
    convert(10'h3FF, 1'b0, 1'b1);
    asc_host_model_i.write_byte(8'h00);
    convert(10'h083, 1'b0, 1'b1);
    t_read(1'b1, 10'h3FF, 1'b0);
    t_read(1'b1, 10'h083, 1'b0);
    t_shared_write();
    results();
  end
endmodule // tb_adc_serial_port_conv_ctrl
